// ---- common/dss_pkg.sv ----
// package for the dual axis synchronized stop block
// assumes one control-cycle clock; users import dss_pkg::*
`default_nettype none
package dss_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_END_SPD = 8'h04;
    localparam logic [7:0] OFS_FF = 8'h08;
    localparam logic [7:0] OFS_MF = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_WARN = 8'h14;
    // ------------------------------------------------------------
    // reset values, ranges and field positions
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [15:0] END_SPD_RST = 16'h0100;
    localparam logic [15:0] END_SPD_MIN = 16'h0001;
    localparam logic [6:0] FF_RST = 7'h50;
    localparam logic [6:0] FF_MAX = 7'h64;
    localparam logic [1:0] MF_RST = 2'h0;
    localparam int MF_EN_BIT = 0;
    localparam int MF_COMB_BIT = 1;
    localparam int STOP_FLAG_BIT = 31;
    localparam logic [11:0] WARN_CODE = 12'h97c;
    // end speed unit is 1000 reference units per second
    localparam logic [9:0] END_SPD_UNIT = 10'h3e8;
    localparam logic [6:0] PERCENT = 7'h64;
    // ------------------------------------------------------------
    // mode codes, follower control kinds, host commands
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_POS = 2'h1;
    localparam logic [1:0] MODE_SPD = 2'h2;
    localparam logic [1:0] MODE_SOFF = 2'h3;
    localparam logic [1:0] CTRL_NONE = 2'h0;
    localparam logic [1:0] CTRL_POS = 2'h1;
    localparam logic [1:0] CTRL_SPD = 2'h2;
    localparam logic [7:0] CMD_SERVO_OFF = 8'h32;
    localparam logic [7:0] CMD_DISCONNECT = 8'h0f;
    localparam logic [7:0] CMD_EMERGENCY = 8'h3f;
    // alarm codes that leave no valid position data
    localparam logic [11:0] ALM_NOPOS [9] = '{12'h810, 12'h820,
        12'h840, 12'h850, 12'h890, 12'h891, 12'hc90, 12'hc91,
        12'hc92};
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic alarm;
        logic [11:0] code;
        logic servo_on;
        logic signed [31:0] pos;
        logic signed [31:0] spd;
    } dss_axis_s;
    typedef struct packed {
        logic [1:0] ctrl;
        logic signed [31:0] pos;
        logic signed [31:0] spd;
        logic signed [31:0] ff;
    } dss_follow_s;
    typedef struct packed {
        logic valid;
        logic [7:0] code;
    } dss_cmd_s;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_TRACK = 3'b010,
        ST_SOFF = 3'b100
    } dss_state_e;
endpackage : dss_pkg
`default_nettype wire

// ---- logic/dss_core.sv ----
// coordinated stop of two servo axes after an alarm on either one
// assumes synchronous inputs, one control cycle per clk_i edge,
// and that each axis servo loop obeys the follower control outputs
//
// Function
// - alarm on one axis makes the other axis follow it to rest.
// - mode 0 off, 1 position, 2 speed, 3 servo off; active after restart.
// - mode 1 tracks the alarmed axis feedback position.
// - mode 2 tracks the alarmed axis feedback speed.
// - mode 3 turns the follower servo off at once.
// - mode 3 leaves the stop status flag at zero.
// - during a stop only emergency commands are accepted.
// - stop ends with servo off and flag clear on three causes.
// - end speed test uses alarmed axis speed, modes 1 and 2 only.
// - end speed 1..65535 in 1000 units/s, default 256, immediate.
// - after the stop ends all host commands are accepted again.
// - mode 1 speed feedforward 0..100 percent, default 80, immediate.
// - under model following, feedforward needs combined selection.
// - alarm without position data gives plain follower servo off.
// - encoder alarm codes listed in the package lack position data.
// - stop status appears in bit 31 of the command io status field.
// - a coordinated stop raises warning code 97c.
// - follower alarm during a stop cancels the coordinated stop.
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dss_core
    import dss_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic restart_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [31:0] reg_rdata_o,
    input wire dss_axis_s axis_a_i,
    input wire dss_axis_s axis_b_i,
    input wire dss_cmd_s host_cmd_i,
    output logic host_cmd_accept_o,
    input wire logic [30:0] io_status_base_i,
    output logic [31:0] servo_cmd_io_status_field_o,
    output logic follow_axis_b_o,
    output dss_follow_s follow_o,
    output logic [1:0] servo_off_command_o,
    output logic warn_o,
    output logic [11:0] warn_code_o
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic no_pos_data(input logic [11:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (code == ALM_NOPOS[i]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : no_pos_data

    function automatic logic is_emergency(input logic [7:0] code);
        return code == CMD_EMERGENCY || code == CMD_SERVO_OFF ||
            code == CMD_DISCONNECT;
    endfunction : is_emergency

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [1:0] mode_cfg_q;
    logic [1:0] mode_act_q;
    logic [15:0] coord_stop_end_speed_q;
    logic [6:0] coord_stop_speed_feedforward_q;
    logic [1:0] model_following_select_q;
    logic warn_q;
    logic coord_stop_status_flag_q;
    logic follow_b_q;
    logic alarm_a_q;
    logic alarm_b_q;
    dss_state_e state_q;
    dss_state_e state_d;
    dss_follow_s follow_q;
    logic [1:0] soff_q;
    logic [31:0] rdata_q;

    // software writes; range limits enforced on entry
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_cfg_q <= MODE_RST;
            coord_stop_end_speed_q <= END_SPD_RST;
            coord_stop_speed_feedforward_q <= FF_RST;
            model_following_select_q <= MF_RST;
        end else if (reg_we_i) begin
            unique case (reg_addr_i)
                OFS_MODE: mode_cfg_q <= reg_wdata_i[1:0];
                OFS_END_SPD: begin
                    // zero is outside the range, held at the floor
                    coord_stop_end_speed_q <= (reg_wdata_i[15:0] == 16'h0)
                        ? END_SPD_MIN : reg_wdata_i[15:0];
                end
                OFS_FF: begin
                    coord_stop_speed_feedforward_q <=
                        (reg_wdata_i > {25'h0, FF_MAX})
                        ? FF_MAX : reg_wdata_i[6:0];
                end
                OFS_MF: model_following_select_q <= reg_wdata_i[1:0];
                default: ;
            endcase
        end
    end

    // mode in use only changes on restart so a stop never sees a swap
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_act_q <= MODE_RST;
        end else if (restart_i) begin
            mode_act_q <= mode_cfg_q;
        end
    end

    // ------------------------------------------------------------
    // alarm events and selection of the alarmed axis
    // ------------------------------------------------------------
    logic rise_a;
    logic rise_b;
    logic trig;
    logic trig_b_alarmed;
    logic [11:0] trig_code;
    assign rise_a = axis_a_i.alarm & ~alarm_a_q;
    assign rise_b = axis_b_i.alarm & ~alarm_b_q;
    // axis a wins when both raise an alarm in the same cycle; an alarm
    // that joins one already standing starts nothing
    assign trig = (rise_a & ~axis_b_i.alarm) | (rise_b & ~axis_a_i.alarm)
        | (rise_a & rise_b);
    assign trig_b_alarmed = ~rise_a;
    assign trig_code = trig_b_alarmed ? axis_b_i.code : axis_a_i.code;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_a_q <= 1'b0;
            alarm_b_q <= 1'b0;
        end else begin
            alarm_a_q <= axis_a_i.alarm;
            alarm_b_q <= axis_b_i.alarm;
        end
    end

    // ------------------------------------------------------------
    // alarmed axis feedback and follower view
    // ------------------------------------------------------------
    // the start cycle must already use the new choice, not the old one
    logic follow_b_d;
    dss_axis_s src;
    dss_axis_s fol;
    assign follow_b_d = (state_q == ST_IDLE && trig) ? !trig_b_alarmed
        : follow_b_q;
    assign src = follow_b_d ? axis_a_i : axis_b_i;
    assign fol = follow_b_d ? axis_b_i : axis_a_i;

    // end speed test, absolute speed against threshold times unit
    logic [31:0] src_abs;
    logic [25:0] end_lim;
    logic below_end;
    assign src_abs = src.spd[31] ? 32'(-src.spd) : 32'(src.spd);
    assign end_lim = 26'(coord_stop_end_speed_q * END_SPD_UNIT);
    assign below_end = src_abs < 32'(end_lim);

    logic host_end;
    assign host_end = host_cmd_i.valid &&
        (host_cmd_i.code == CMD_SERVO_OFF ||
         host_cmd_i.code == CMD_DISCONNECT);

    // feedforward only where the model following choice permits it
    logic ff_on;
    logic signed [39:0] ff_prod;
    assign ff_on = mode_act_q == MODE_POS &&
        (!model_following_select_q[MF_EN_BIT] ||
         model_following_select_q[MF_COMB_BIT]);
    assign ff_prod = 40'(src.spd * $signed({1'b0,
        coord_stop_speed_feedforward_q}));

    // ------------------------------------------------------------
    // stop sequencer
    // ------------------------------------------------------------
    logic start_track;
    logic start_soff;
    logic end_track;
    logic cancel;
    assign start_track = state_q == ST_IDLE && trig &&
        (mode_act_q == MODE_POS || mode_act_q == MODE_SPD) &&
        !no_pos_data(trig_code);
    assign start_soff = state_q == ST_IDLE && trig &&
        mode_act_q != MODE_OFF && !start_track;
    assign cancel = state_q == ST_TRACK && fol.alarm;
    assign end_track = state_q == ST_TRACK && !cancel &&
        (below_end || host_end || !fol.servo_on);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (start_track) begin
                    state_d = ST_TRACK;
                end else if (start_soff) begin
                    state_d = ST_SOFF;
                end
            end
            ST_TRACK: begin
                if (cancel) begin
                    state_d = ST_IDLE;
                end else if (end_track) begin
                    state_d = ST_SOFF;
                end
            end
            ST_SOFF: begin
                // hold the off request until the follower reports off
                if (!fol.servo_on) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            follow_b_q <= 1'b0;
        end else begin
            state_q <= state_d;
            follow_b_q <= follow_b_d;
        end
    end

    // flag is set together with a tracking start, never in mode 3 or on a plain servo off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            coord_stop_status_flag_q <= 1'b0;
        end else if (start_track) begin
            coord_stop_status_flag_q <= 1'b1;
        end else if (end_track || cancel) begin
            coord_stop_status_flag_q <= 1'b0;
        end
    end

    // follower targets refresh every cycle while tracking
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            follow_q <= '0;
        end else if (state_d == ST_TRACK) begin
            follow_q.ctrl <= (mode_act_q == MODE_POS) ? CTRL_POS
                : CTRL_SPD;
            follow_q.pos <= src.pos;
            follow_q.spd <= src.spd;
            follow_q.ff <= ff_on ? 32'(ff_prod / $signed({33'h0, PERCENT}))
                : 32'sd0;
        end else begin
            follow_q <= '0;
        end
    end

    // servo off request toward the follower axis
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            soff_q <= 2'h0;
        end else if (state_d == ST_SOFF) begin
            soff_q <= (state_q == ST_IDLE ? !trig_b_alarmed : follow_b_q)
                ? 2'h2 : 2'h1;
        end else begin
            soff_q <= 2'h0;
        end
    end

    // sticky warning, a new stop wins over a software clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            warn_q <= 1'b0;
        end else if (start_track || start_soff) begin
            warn_q <= 1'b1;
        end else if (reg_we_i && reg_addr_i == OFS_WARN &&
                     reg_wdata_i[0]) begin
            warn_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // register read port, one cycle latency, unmapped reads zero
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0;
        end else if (reg_re_i) begin
            unique case (reg_addr_i)
                OFS_MODE: rdata_q <= {28'h0, mode_act_q, mode_cfg_q};
                OFS_END_SPD: rdata_q <= {16'h0, coord_stop_end_speed_q};
                OFS_FF: rdata_q <= {25'h0, coord_stop_speed_feedforward_q};
                OFS_MF: rdata_q <= {30'h0, model_following_select_q};
                OFS_STATUS: rdata_q <= {26'h0, follow_b_q, state_q,
                    coord_stop_status_flag_q, warn_q};
                OFS_WARN: rdata_q <= {3'h0, WARN_CODE, 16'h0, warn_q};
                default: rdata_q <= 32'h0;
            endcase
        end else begin
            rdata_q <= 32'h0;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // command gate is combinational so the host sees refusal at once
    assign host_cmd_accept_o = host_cmd_i.valid &&
        (state_q != ST_TRACK ||
         is_emergency(host_cmd_i.code));
    assign servo_cmd_io_status_field_o = {coord_stop_status_flag_q,
        io_status_base_i};
    assign reg_rdata_o = rdata_q;
    assign follow_axis_b_o = follow_b_q;
    assign follow_o = follow_q;
    assign servo_off_command_o = soff_q;
    assign warn_o = warn_q;
    assign warn_code_o = warn_q ? WARN_CODE : 12'h0;
endmodule : dss_core
`default_nettype wire

// ---- sim/dss_core_assertions.sv ----
// port checker for the coordinated stop core
// assumes one clock clk_i with synchronous active-high rst_i
`timescale 1ns/1ps
`default_nettype none
module dss_core_assertions
    import dss_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire dss_axis_s axis_a_i,
    input wire dss_axis_s axis_b_i,
    input wire dss_cmd_s host_cmd_i,
    input wire logic host_cmd_accept_o,
    input wire logic [30:0] io_status_base_i,
    input wire logic [31:0] servo_cmd_io_status_field_o,
    input wire logic follow_axis_b_o,
    input wire dss_follow_s follow_o,
    input wire logic [1:0] servo_off_command_o,
    input wire logic warn_o,
    input wire logic [11:0] warn_code_o
);
    // ----
    // helpers: stop flag, command class, follower axis
    // ----
    logic flag;
    logic off_cmd;
    dss_axis_s fol;
    assign flag = servo_cmd_io_status_field_o[STOP_FLAG_BIT];
    assign off_cmd = host_cmd_i.valid && (host_cmd_i.code == CMD_SERVO_OFF
        || host_cmd_i.code == CMD_DISCONNECT);
    assign fol = follow_axis_b_o ? axis_b_i : axis_a_i;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_io_base_pass: assert property (
        servo_cmd_io_status_field_o[30:0] == io_status_base_i)
        else $error("status low bits not passed");
    a_warn_code_tie: assert property (
        warn_code_o == (warn_o ? WARN_CODE : 12'h000))
        else $error("warning code mismatch");
    a_cmd_gate: assert property (
        host_cmd_accept_o == (host_cmd_i.valid && (!flag || off_cmd
        || host_cmd_i.code == CMD_EMERGENCY)))
        else $error("command gating wrong");
    a_idle_no_follow: assert property (!flag |-> follow_o == '0)
        else $error("follower driven outside a stop");
    a_pos_target: assert property (
        flag && follow_o.ctrl == CTRL_POS |-> follow_o.pos ==
        (follow_axis_b_o ? $past(axis_a_i.pos) : $past(axis_b_i.pos)))
        else $error("position target wrong");
    a_spd_target: assert property (
        flag && follow_o.ctrl == CTRL_SPD |-> follow_o.spd ==
        (follow_axis_b_o ? $past(axis_a_i.spd) : $past(axis_b_i.spd)))
        else $error("speed target wrong");
    a_host_off_end: assert property (
        flag && off_cmd && !fol.alarm |=> !flag && servo_off_command_o ==
        ($past(follow_axis_b_o) ? 2'b10 : 2'b01))
        else $error("host off did not end the stop");
    a_fol_off_end: assert property (
        flag && !fol.servo_on |=> !flag)
        else $error("follower servo off did not end the stop");
    a_fol_alarm_cancel: assert property (
        flag && fol.alarm |=> !flag && servo_off_command_o == 2'b00)
        else $error("follower alarm did not cancel");
    a_start_sets: assert property (
        $rose(flag) |-> warn_o && follow_o.ctrl != CTRL_NONE)
        else $error("stop start incomplete");
endmodule : dss_core_assertions
bind dss_core dss_core_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .axis_a_i(axis_a_i), .axis_b_i(axis_b_i), .host_cmd_i(host_cmd_i),
    .host_cmd_accept_o(host_cmd_accept_o),
    .io_status_base_i(io_status_base_i),
    .servo_cmd_io_status_field_o(servo_cmd_io_status_field_o),
    .follow_axis_b_o(follow_axis_b_o), .follow_o(follow_o),
    .servo_off_command_o(servo_off_command_o), .warn_o(warn_o),
    .warn_code_o(warn_code_o));
`default_nettype wire

// ---- sim/dss_axes_model.sv ----
// behavioural pair of servo axes facing the coordinated stop core
// assumes the bench drives alarms, codes and the lag request
`timescale 1ns/1ps
`default_nettype none
module dss_axes_model
    import dss_pkg::*;
#(
    parameter logic signed [31:0] SPD0 = 32'sh000f4240,
    parameter logic signed [31:0] DECEL = 32'sh000186a0
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] alarm_i,
    input wire logic [11:0] code_i,
    input wire logic lag_i,
    input wire logic [1:0] servo_off_command_i,
    output dss_axis_s axis_a_o,
    output dss_axis_s axis_b_o
);
    dss_axis_s ax_q [2];
    // alarmed axis brakes to rest; lag_i models a slow amplifier
    // that keeps servo on despite an off request
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 2; i++) begin
            if (rst_i) begin
                // axes start one unit apart so a swapped target shows
                ax_q[i] <= '{1'b0, 12'h000, 1'b1, 32'(i), SPD0};
            end else begin
                ax_q[i].pos <= ax_q[i].pos + ax_q[i].spd;
                if (alarm_i[i]) begin
                    ax_q[i].spd <= (ax_q[i].spd > DECEL) ?
                        ax_q[i].spd - DECEL : 32'sh0;
                end
                if (alarm_i[i] || (servo_off_command_i[i] && !lag_i)) begin
                    ax_q[i].servo_on <= 1'b0;
                end
            end
        end
    end
    // alarm and code are live so the core sees them at once
    always_comb begin
        axis_a_o = ax_q[0];
        axis_a_o.alarm = alarm_i[0];
        axis_a_o.code = code_i;
        axis_b_o = ax_q[1];
        axis_b_o.alarm = alarm_i[1];
        axis_b_o.code = code_i;
    end
endmodule : dss_axes_model
`default_nettype wire

// ---- sim/dss_core_bench.sv ----
// bench for the coordinated stop core with the axis pair model
// assumes dss_pkg, the model and the bound checker are compiled
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp); \
        end \
    end
module dss_core_bench
    import dss_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic restart = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic we = 1'b0;
    logic re = 1'b0;
    logic [31:0] rdata;
    dss_axis_s ax_a;
    dss_axis_s ax_b;
    dss_cmd_s cmd_q = '0;
    logic accept;
    logic [31:0] io;
    logic fol_b;
    dss_follow_s fw;
    logic [1:0] off;
    logic warn;
    logic [1:0] alarm = 2'b00;
    logic [11:0] code = 12'h000;
    logic lag = 1'b0;
    int failures = 0;
    int total_checks = 0;
    int cyc = 0;
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    dss_core dut (.clk_i(clk_i), .rst_i(rst_i), .restart_i(restart),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we),
        .reg_re_i(re), .reg_rdata_o(rdata), .axis_a_i(ax_a),
        .axis_b_i(ax_b), .host_cmd_i(cmd_q), .host_cmd_accept_o(accept),
        .io_status_base_i(31'h2a5a5a5a), .servo_cmd_io_status_field_o(io),
        .follow_axis_b_o(fol_b), .follow_o(fw), .servo_off_command_o(off),
        .warn_o(warn), .warn_code_o());
    dss_axes_model u_axes (.clk_i(clk_i), .rst_i(rst_i), .alarm_i(alarm),
        .code_i(code), .lag_i(lag), .servo_off_command_i(off),
        .axis_a_o(ax_a), .axis_b_o(ax_b));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk_i);
        we <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        addr <= a;
        re <= 1'b1;
        @(posedge clk_i);
        re <= 1'b0;
        @(negedge clk_i);
        `CHK(rdata, exp)
    endtask : rdc
    // reset core and axes, configure, then restart to load the mode
    task automatic arm(input logic [1:0] m, input logic [31:0] mf);
        @(posedge clk_i);
        rst_i <= 1'b1;
        alarm <= 2'b00;
        lag <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wr(OFS_MODE, {30'h0, m});
        wr(OFS_END_SPD, 32'h64);
        wr(OFS_MF, mf);
        @(posedge clk_i);
        restart <= 1'b1;
        @(posedge clk_i);
        restart <= 1'b0;
    endtask : arm
    task automatic fire(input logic [1:0] ax, input logic [11:0] c);
        @(posedge clk_i);
        alarm <= ax;
        code <= c;
        repeat (2) @(negedge clk_i);
    endtask : fire
    task automatic cmd(input logic [7:0] c, input logic exp);
        @(posedge clk_i);
        cmd_q <= '{1'b1, c};
        @(negedge clk_i);
        `CHK(accept, exp)
        @(posedge clk_i);
        cmd_q <= '0;
    endtask : cmd
    task automatic end_of_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test
    // cycle ceiling well above the few hundred cycles of the run
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            failures++;
            end_of_test();
        end
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(OFS_MODE, 32'h0);
        rdc(OFS_END_SPD, 32'h100);
        rdc(OFS_FF, 32'h50);
        rdc(OFS_MF, 32'h0);
        rdc(8'h20, 32'h0);
        wr(OFS_END_SPD, 32'h0);
        rdc(OFS_END_SPD, 32'h1);
        wr(OFS_FF, 32'h7f);
        rdc(OFS_FF, 32'h64);
        // configured mode without restart must stay disabled
        arm(2'h0, 32'h0);
        wr(OFS_MODE, 32'h1);
        fire(2'b01, 12'h100);
        `CHK({io[31], off, warn}, 4'h0)
        rdc(OFS_MODE, 32'h1);
        // position following, only emergency commands, normal end
        arm(2'h1, 32'h0);
        rdc(OFS_MODE, 32'h5);
        fire(2'b01, 12'h100);
        `CHK({io[31], fol_b, fw.ctrl, warn}, {2'b11, CTRL_POS, 1'b1})
        `CHK(fw.ff, 32'sh000c3500)
        cmd(8'h01, 1'b0);
        cmd(CMD_EMERGENCY, 1'b1);
        @(negedge clk_i);
        `CHK(io[31], 1'b1)
        for (int n = 0; n < 40 && io[31] !== 1'b0; n++) @(negedge clk_i);
        `CHK({io[31], off}, 3'b010)
        cmd(8'h01, 1'b1);
        @(negedge clk_i);
        `CHK(off, 2'b00)
        // model following without combined selection, follower alarm
        arm(2'h1, 32'h1);
        fire(2'b01, 12'h100);
        `CHK(fw.ff, 32'sh0)
        @(posedge clk_i);
        alarm <= 2'b11;
        repeat (2) @(negedge clk_i);
        `CHK({io[31], off, fw.ctrl}, 5'h00)
        // combined model following keeps the feedforward
        arm(2'h1, 32'h3);
        fire(2'b01, 12'h100);
        `CHK(fw.ff, 32'sh000c3500)
        // speed following ended by each host end command
        for (int k = 0; k < 2; k++) begin
            arm(2'h2, 32'h0);
            fire(2'b10, 12'h100);
            `CHK({io[31], fol_b, fw.ctrl}, {2'b10, CTRL_SPD})
            cmd(k ? CMD_DISCONNECT : CMD_SERVO_OFF, 1'b1);
            @(negedge clk_i);
            `CHK({io[31], off}, 3'b001)
        end
        // immediate servo off with a slow follower, then warning clear
        arm(2'h3, 32'h0);
        @(posedge clk_i);
        lag <= 1'b1;
        fire(2'b01, 12'h100);
        `CHK({io[31], off, warn}, 4'b0101)
        repeat (4) @(negedge clk_i);
        `CHK(off, 2'b10)
        @(posedge clk_i);
        lag <= 1'b0;
        repeat (3) @(negedge clk_i);
        `CHK(off, 2'b00)
        rdc(OFS_WARN, 32'h12f80001);
        wr(OFS_WARN, 32'h1);
        rdc(OFS_WARN, 32'h12f80000);
        // alarms without position data give plain servo off
        for (int i = 0; i < 9; i++) begin
            arm(2'h1, 32'h0);
            fire(2'b01, ALM_NOPOS[i]);
            `CHK({io[31], off}, 3'b010)
        end
        end_of_test();
    end
endmodule : dss_core_bench
`default_nettype wire
